// *** sdbseq_contactor.sv ***
// Behavioural model of the brake contactor and its feedback contact.
// Assumes the coil command and test pulse come from the sequencer on i_clock.
`timescale 1ns/100ps
`default_nettype none

module sdbseq_contactor #(
    parameter int MECH_CYC = 40
) (
    input wire logic i_clock,
    input wire logic i_coil,
    input wire logic i_pulse,
    input wire logic [1:0] i_mode,
    output logic o_feedback
);
    int cnt = 0;
    logic closed = 1'b0;

    // Armature follows the coil only after a mechanical delay, as a real part does.
    always @(posedge i_clock) begin
        if (i_coil != closed && cnt >= MECH_CYC) begin
            closed <= i_coil;
            cnt <= 0;
        end else begin
            cnt <= (i_coil != closed) ? cnt + 1 : 0;
        end
    end

    // Mode 0 passes the test pulse through the closed contact, 1 never closes,
    // 2 loses the pulses (static level), 3 is welded shut.
    assign o_feedback = (i_mode == 2'd1) ? 1'b0 :
                        (i_mode == 2'd2) ? closed :
                        (i_mode == 2'd3) ? 1'b1 : closed & i_pulse;
endmodule
`default_nettype wire

// *** sdbseq_pkg.sv ***
// Package for the per-axis dynamic brake sequencer.
// Assumes a 20 MHz system clock and a plain strobe register port.
package sdbseq_pkg;

    // Clock and the microsecond time base.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned US_NS = 1000;
    localparam int unsigned CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam logic [4:0] US_DIV_LAST = 5'(CYC_PER_US - 1);

    // Delay register resets, in microseconds (1 ms each).
    localparam logic [15:0] SW_DELAY_US_RST = 16'h03E8;
    localparam logic [15:0] DG_DELAY_US_RST = 16'h03E8;

    // Test pulse pattern and feedback supervision limits, in microseconds.
    localparam logic [15:0] PULSE_PERIOD_US = 16'h01F4;
    localparam logic [15:0] PULSE_LOW_US = 16'h0002;
    localparam logic [15:0] STATIC_LIMIT_US = 16'h05DC;
    localparam logic [15:0] LOW_LIMIT_US = 16'h000A;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SW_DELAY = 8'h04;
    localparam logic [7:0] ADDR_DG_DELAY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;

    // Number of safe inputs that may serve as feedback.
    localparam int unsigned NUM_SAFE_IN = 4;

    // Control register layout, bits [3:0].
    typedef struct packed {
        logic [1:0] fb_sel;
        logic pulse_en;
        logic enable;
    } sdbseq_ctrl_t;
    localparam sdbseq_ctrl_t CTRL_RST = 4'h0;

    // Event layout shared by the status, enable and clear registers, bits [3:0].
    typedef struct packed {
        logic torque_rel;
        logic engaged;
        logic fault;
        logic io_err;
    } sdbseq_evt_t;
    localparam sdbseq_evt_t EVT_RST = 4'h0;

    // Live status register layout, bits [4:0].
    typedef struct packed {
        logic fb_level;
        logic diag_active;
        logic torque_rel;
        logic dyn_status;
        logic brake_cmd;
    } sdbseq_stat_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_ACT_WAIT,
        ST_ACT_DIAG,
        ST_BRAKED,
        ST_REL
    } sdbseq_state_t;

endpackage

// *** sdbseq_top.sv ***
// Dynamic brake sequencer for one axis: contactor command, delays, feedback check.
// Assumes all inputs are synchronous to i_clock and a single-cycle strobe bus.
//
// Behaviour
// R1: Brake sequence runs with the torque-off sequence.
// R2: Activation commands contactor to short motor terminals.
// R3: Status shown while motor lines are shorted.
// R4: One instance per axis with own settings.
// R5: Activation output plus contactor feedback input.
// R6: Setting selects which safe input is feedback.
// R7: Feedback path carries pulsed test signal.
// R8: Contactor state is supervised through feedback.
// R9: Restart first releases contactor, suspends checking.
// R10: Torque allowed only after switch delay elapses.
// R11: Checking resumes after diagnosis delay on restart.
// R12: Switch delay from request, default 1 ms.
// R13: Diagnosis delay after switching, default 1 ms.
// R14: Switch delay bounds contactor release time.
// R15: System should activate the brake regularly.
// R16: Static feedback signal flags an I/O error.
// R17: Wrong feedback level flags a brake failure.
// R18: Checking masked from switch delay to diagnosis end.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module sdbseq_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_torque_off_req,
    input wire logic i_restart_ok,
    input wire logic [3:0] i_safe_in,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_brake_activate,
    output logic o_dyn_brake_status,
    output logic o_torque_release,
    output logic o_test_pulse,
    output logic o_irq
);

    sdbseq_pkg::sdbseq_state_t state_reg, state_next;
    sdbseq_pkg::sdbseq_ctrl_t ctrl_reg;
    sdbseq_pkg::sdbseq_evt_t irq_stat_reg, irq_stat_next, irq_en_reg, evt;
    sdbseq_pkg::sdbseq_stat_t live;
    logic [15:0] sw_delay_reg, dg_delay_reg;
    logic [15:0] sw_cnt_reg, sw_cnt_next, dg_cnt_reg, dg_cnt_next;
    logic [15:0] static_cnt_reg, low_cnt_reg, pulse_cnt_reg;
    logic [4:0] div_reg;
    logic brake_reg, torque_reg, fb_q_reg, pulse_reg;
    logic [31:0] rdata_reg;

    // Register decode.
    wire wr_ctrl = i_wr && (i_addr == sdbseq_pkg::ADDR_CTRL);
    wire wr_sw = i_wr && (i_addr == sdbseq_pkg::ADDR_SW_DELAY);
    wire wr_dg = i_wr && (i_addr == sdbseq_pkg::ADDR_DG_DELAY);
    wire wr_en = i_wr && (i_addr == sdbseq_pkg::ADDR_IRQ_EN);
    wire wr_clr = i_wr && (i_addr == sdbseq_pkg::ADDR_IRQ_CLR);

    // Sequencer decode; a load restarts the time base so each delay is exact.
    wire sw_zero = (sw_cnt_reg == 16'h0000);
    wire dg_zero = (dg_cnt_reg == 16'h0000);
    wire load_sw = (state_next != state_reg) &&
                   ((state_next == sdbseq_pkg::ST_ACT_WAIT) || (state_next == sdbseq_pkg::ST_REL));
    wire load_dg = (state_next != state_reg) &&
                   ((state_next == sdbseq_pkg::ST_ACT_DIAG) || (state_next == sdbseq_pkg::ST_REL));
    wire us_tick = (div_reg == sdbseq_pkg::US_DIV_LAST);

    // Feedback selection and supervision decode.
    wire fb_level = i_safe_in[ctrl_reg.fb_sel]; // see R6
    wire fb_edge = (fb_level != fb_q_reg);
    wire expect_high = brake_reg;
    // Clearing the enable in mid-sequence is not supported: the state machine
    // runs on through the sequence while torque falls back to following the request.
    // Checking is masked in every transitional state. see R18
    wire diag_active = ctrl_reg.enable &&
                       ((state_reg == sdbseq_pkg::ST_BRAKED) || (state_reg == sdbseq_pkg::ST_RUN));
    wire watch_high = diag_active && expect_high;
    wire static_hit = watch_high && us_tick && !fb_edge &&
                      (static_cnt_reg == sdbseq_pkg::STATIC_LIMIT_US - 16'h0001);
    wire low_hit = watch_high && us_tick && !fb_level &&
                   (low_cnt_reg == sdbseq_pkg::LOW_LIMIT_US - 16'h0001);
    wire pulse_low = (pulse_cnt_reg < sdbseq_pkg::PULSE_LOW_US);
    wire pulse_wrap = (pulse_cnt_reg == sdbseq_pkg::PULSE_PERIOD_US - 16'h0001);

    // Next-state logic of the brake sequence.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sdbseq_pkg::ST_RUN: begin
                if (ctrl_reg.enable && i_torque_off_req) begin
                    state_next = sdbseq_pkg::ST_ACT_WAIT; // see R1
                end
            end
            sdbseq_pkg::ST_ACT_WAIT: begin
                if (sw_zero) begin
                    state_next = sdbseq_pkg::ST_ACT_DIAG; // see R12
                end
            end
            sdbseq_pkg::ST_ACT_DIAG: begin
                if (dg_zero) begin
                    state_next = sdbseq_pkg::ST_BRAKED; // see R13
                end
            end
            sdbseq_pkg::ST_BRAKED: begin
                if (!i_torque_off_req && i_restart_ok) begin
                    state_next = sdbseq_pkg::ST_REL; // see R9
                end
            end
            sdbseq_pkg::ST_REL: begin
                if (i_torque_off_req) begin
                    state_next = sdbseq_pkg::ST_ACT_WAIT;
                end else if (sw_zero && dg_zero) begin
                    state_next = sdbseq_pkg::ST_RUN; // see R11
                end
            end
        endcase
    end

    // Delay counters count whole microseconds down to zero.
    always_comb begin
        sw_cnt_next = sw_cnt_reg;
        dg_cnt_next = dg_cnt_reg;
        if (load_sw) begin
            sw_cnt_next = sw_delay_reg; // see R12 R14
        end else if (us_tick && !sw_zero) begin
            sw_cnt_next = sw_cnt_reg - 16'h0001;
        end
        if (load_dg) begin
            dg_cnt_next = dg_delay_reg; // see R13
        end else if (us_tick && !dg_zero) begin
            dg_cnt_next = dg_cnt_reg - 16'h0001;
        end
    end

    // Contactor command and torque permission, taken from the next state.
    // Without the function configured, torque simply follows the request.
    wire brake_next = (state_next == sdbseq_pkg::ST_ACT_DIAG) ||
                      (state_next == sdbseq_pkg::ST_BRAKED); // see R2
    wire torque_next = ctrl_reg.enable ?
                       ((state_next == sdbseq_pkg::ST_RUN) ||
                        ((state_next == sdbseq_pkg::ST_REL) && (sw_cnt_next == 16'h0000))) :
                       !i_torque_off_req; // see R10

    // Event sources for the sticky status register.
    always_comb begin
        evt = sdbseq_pkg::EVT_RST;
        evt.io_err = static_hit; // see R16
        evt.fault = low_hit || (diag_active && !expect_high && fb_level); // see R17 R8
        evt.engaged = (state_reg == sdbseq_pkg::ST_ACT_DIAG) &&
                      (state_next == sdbseq_pkg::ST_BRAKED);
        evt.torque_rel = (state_reg == sdbseq_pkg::ST_REL) &&
                         (state_next == sdbseq_pkg::ST_RUN);
    end

    // A set arriving with a clear wins, so no event is lost.
    assign irq_stat_next = (irq_stat_reg & ~(wr_clr ? i_wdata[3:0] : 4'h0)) | evt;

    // Live status view, built as one word so the struct has a single driver.
    assign live = {fb_level, diag_active, torque_reg, brake_reg, brake_reg};

    // Read multiplexer; unmapped and write-only offsets read as zero.
    wire [31:0] rd_mux =
        (i_addr == sdbseq_pkg::ADDR_CTRL) ? {28'h0000000, ctrl_reg} :
        (i_addr == sdbseq_pkg::ADDR_SW_DELAY) ? {16'h0000, sw_delay_reg} :
        (i_addr == sdbseq_pkg::ADDR_DG_DELAY) ? {16'h0000, dg_delay_reg} :
        (i_addr == sdbseq_pkg::ADDR_STATUS) ? {27'h0000000, live} :
        (i_addr == sdbseq_pkg::ADDR_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
        (i_addr == sdbseq_pkg::ADDR_IRQ_EN) ? {28'h0000000, irq_en_reg} :
        32'h00000000;

    // Configuration registers; each axis instance keeps its own set. see R4
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_reg <= sdbseq_pkg::CTRL_RST;
            sw_delay_reg <= sdbseq_pkg::SW_DELAY_US_RST;
            dg_delay_reg <= sdbseq_pkg::DG_DELAY_US_RST;
            irq_en_reg <= sdbseq_pkg::EVT_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= i_wdata[3:0];
            if (wr_sw) sw_delay_reg <= i_wdata[15:0];
            if (wr_dg) dg_delay_reg <= i_wdata[15:0];
            if (wr_en) irq_en_reg <= i_wdata[3:0];
        end
    end

    // Interrupt status and read data; read data stand one cycle only.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            irq_stat_reg <= sdbseq_pkg::EVT_RST;
            rdata_reg <= 32'h00000000;
        end else begin
            irq_stat_reg <= irq_stat_next;
            rdata_reg <= i_rd ? rd_mux : 32'h00000000;
        end
    end

    // Sequencer state, delay counters and outputs.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= sdbseq_pkg::ST_RUN;
            sw_cnt_reg <= 16'h0000;
            dg_cnt_reg <= 16'h0000;
            brake_reg <= 1'b0;
            torque_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sw_cnt_reg <= sw_cnt_next;
            dg_cnt_reg <= dg_cnt_next;
            brake_reg <= brake_next; // see R5
            torque_reg <= torque_next;
        end
    end

    // Microsecond divider; restarting it on a load trades a free-running
    // base for delays that are exact to the clock.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || load_sw || load_dg || us_tick) begin
            div_reg <= 5'h00;
        end else begin
            div_reg <= div_reg + 5'h01;
        end
    end

    // Static and low-time supervision of the pulsed feedback.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !watch_high || fb_edge) begin
            static_cnt_reg <= 16'h0000;
        end else if (us_tick && (static_cnt_reg != sdbseq_pkg::STATIC_LIMIT_US)) begin
            static_cnt_reg <= static_cnt_reg + 16'h0001; // see R16
        end
        if (!i_rst_n || !watch_high || fb_level) begin
            low_cnt_reg <= 16'h0000;
        end else if (us_tick && (low_cnt_reg != sdbseq_pkg::LOW_LIMIT_US)) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001; // see R17
        end
        fb_q_reg <= i_rst_n ? fb_level : 1'b0;
    end

    // Test pulse source: on, with a short dip each period. see R7
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || (us_tick && pulse_wrap)) begin
            pulse_cnt_reg <= 16'h0000;
        end else if (us_tick) begin
            pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
        end
        pulse_reg <= i_rst_n && ctrl_reg.pulse_en && !pulse_low;
    end

    // The brake should be cycled regularly by the system, since a stuck
    // contactor only shows at a change of state. see R15
    assign o_brake_activate = brake_reg;
    assign o_dyn_brake_status = brake_reg; // see R3
    assign o_torque_release = torque_reg;
    assign o_test_pulse = pulse_reg;
    assign o_rdata = rdata_reg;
    assign o_irq = |(irq_stat_reg & irq_en_reg);

    // Checks on the sequence and supervision.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_torque_follow: assert property ( // see R1
        (state_reg == sdbseq_pkg::ST_RUN) && ctrl_reg.enable && i_torque_off_req
        |=> !o_torque_release && (state_reg == sdbseq_pkg::ST_ACT_WAIT))
        else $error("torque not removed on request");
    a_switch_after: assert property ( // see R12
        $rose(o_brake_activate) |-> $past(state_reg) == sdbseq_pkg::ST_ACT_WAIT && $past(sw_zero))
        else $error("contactor switched before delay");
    a_status_short: assert property ( // see R3
        (state_reg == sdbseq_pkg::ST_BRAKED) |-> o_dyn_brake_status && o_brake_activate)
        else $error("status missing while shorted");
    a_restart_release: assert property ( // see R9
        (state_reg == sdbseq_pkg::ST_BRAKED) && !i_torque_off_req && i_restart_ok
        |=> !o_brake_activate && !diag_active)
        else $error("restart kept contactor or checking");
    a_torque_wait: assert property ( // see R10
        (state_reg == sdbseq_pkg::ST_REL) && !sw_zero |-> !o_torque_release)
        else $error("torque released before switch delay");
    a_diag_masked: assert property ( // see R18
        (state_reg == sdbseq_pkg::ST_ACT_WAIT) || (state_reg == sdbseq_pkg::ST_ACT_DIAG) ||
        (state_reg == sdbseq_pkg::ST_REL) |-> !evt.fault && !evt.io_err)
        else $error("checking during masked interval");
    a_static_flag: assert property ( // see R16
        static_hit |=> irq_stat_reg.io_err)
        else $error("static feedback not flagged");
    a_level_flag: assert property ( // see R17
        diag_active && !expect_high && fb_level |=> irq_stat_reg.fault)
        else $error("wrong feedback level not flagged");
    a_read_once: assert property (
        !$past(i_rd) |-> o_rdata == 32'h00000000)
        else $error("read data outside its cycle");

    // Torque permission: without the function it tracks the request, with it
    // torque returns in the running state, or in release once the switch delay has run out.
    a_torque_plain: assert property ( // see R1
        !ctrl_reg.enable |=> o_torque_release == !$past(i_torque_off_req))
        else $error("torque not following request");
    a_torque_run: assert property ( // see R10
        ctrl_reg.enable && (state_reg == sdbseq_pkg::ST_RUN) && !i_torque_off_req
        |=> o_torque_release)
        else $error("torque withheld while running");
    a_run_open: assert property ( // see R2
        (state_reg == sdbseq_pkg::ST_RUN) |-> !o_brake_activate)
        else $error("contactor closed while running");

    // Order of the sequence: restart, re-entry and the end of each delay.
    // A restart must never be taken in the middle of an activation.
    a_restart_only: assert property ( // see R9
        (state_reg != sdbseq_pkg::ST_BRAKED) && (state_reg != sdbseq_pkg::ST_REL)
        |=> state_reg != sdbseq_pkg::ST_REL)
        else $error("restart taken outside braked state");
    a_rel_reenter: assert property ( // see R1
        (state_reg == sdbseq_pkg::ST_REL) && i_torque_off_req
        |=> state_reg == sdbseq_pkg::ST_ACT_WAIT)
        else $error("request during restart not taken");
    a_diag_resume: assert property ( // see R11
        (state_reg == sdbseq_pkg::ST_RUN) && ($past(state_reg) == sdbseq_pkg::ST_REL)
        |-> $past(sw_zero) && $past(dg_zero))
        else $error("checking resumed before diagnosis delay");
    a_engage_delay: assert property ( // see R13
        (state_reg == sdbseq_pkg::ST_BRAKED) && ($past(state_reg) == sdbseq_pkg::ST_ACT_DIAG)
        |-> $past(dg_zero))
        else $error("braked before diagnosis delay");

    // Flags, clear and test pulse.
    a_low_flag: assert property ( // see R17
        low_hit |=> irq_stat_reg.fault)
        else $error("lost feedback pulse not flagged");
    a_clear_done: assert property (
        wr_clr && i_wdata[1] && !evt.fault |=> !irq_stat_reg.fault)
        else $error("fault bit not cleared");
    a_pulse_off: assert property ( // see R7
        !ctrl_reg.pulse_en |=> !o_test_pulse)
        else $error("test pulse without enable");

    // Main scenarios of the sequence and its supervision.
    c_engaged: cover property (state_reg == sdbseq_pkg::ST_BRAKED);
    c_reenter: cover property ((state_reg == sdbseq_pkg::ST_REL) && i_torque_off_req);
    c_fault: cover property (evt.fault);
    c_restart: cover property (evt.torque_rel);
    c_io_err: cover property (static_hit);

endmodule

`default_nettype wire

// *** sdbseq_top_tb.sv ***
// Self-checking bench for the dynamic brake sequencer with a contactor model.
// Assumes delay registers set to 5 us so each delay is 100 clock cycles.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end

module sdbseq_top_tb;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_torque_off_req = 1'b0;
    logic i_restart_ok = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] mode = 2'd0;
    logic [31:0] o_rdata;
    logic o_brake_activate, o_dyn_brake_status, o_torque_release, o_test_pulse, o_irq, fb;
    logic [31:0] d;
    int error_cnt = 0;
    int total_checks = 0;
    int n;

    always #25 i_clock = ~i_clock;

    sdbseq_contactor cont (.i_clock(i_clock), .i_coil(o_brake_activate),
        .i_pulse(o_test_pulse), .i_mode(mode), .o_feedback(fb));

    // Feedback sits on input 3; the others carry its inverse so a wrong pick shows.
    sdbseq_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_torque_off_req(i_torque_off_req),
        .i_restart_ok(i_restart_ok), .i_safe_in({fb, ~fb, ~fb, ~fb}), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_brake_activate(o_brake_activate), .o_dyn_brake_status(o_dyn_brake_status),
        .o_torque_release(o_torque_release), .o_test_pulse(o_test_pulse), .o_irq(o_irq));

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic reset_cfg(input logic [1:0] m);
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        i_torque_off_req <= 1'b0;
        i_restart_ok <= 1'b0;
        mode <= m;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        wr(sdbseq_pkg::ADDR_SW_DELAY, 32'h5);
        wr(sdbseq_pkg::ADDR_DG_DELAY, 32'h5);
        wr(sdbseq_pkg::ADDR_IRQ_EN, 32'hF);
        wr(sdbseq_pkg::ADDR_CTRL, 32'hF);
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    // Raise the request and count cycles until the contactor is commanded.
    task automatic activate;
        @(posedge i_clock);
        i_torque_off_req <= 1'b1;
        n = 0;
        while (o_brake_activate !== 1'b1 && n < 400) begin
            @(posedge i_clock);
            #1 n++;
            if (n == 3) `CHK("torque off", 1'b0, o_torque_release)
        end
        `CHK("switch delay", 1'b1, (n >= 100 && n <= 104))
        `CHK("brake status", 1'b1, o_dyn_brake_status)
    endtask

    task automatic t_reset_values;
        rd(sdbseq_pkg::ADDR_SW_DELAY, d);
        `CHK("sw delay rst", 32'h3E8, d)
        rd(sdbseq_pkg::ADDR_DG_DELAY, d);
        `CHK("dg delay rst", 32'h3E8, d)
        rd(sdbseq_pkg::ADDR_CTRL, d);
        `CHK("ctrl rst", 32'h0, d)
        rd(8'h1C, d);
        `CHK("unmapped", 32'h0, d)
    endtask

    task automatic t_normal_cycle;
        reset_cfg(2'd0);
        `CHK("torque run", 1'b1, o_torque_release)
        `CHK("pulse dip", 1'b0, o_test_pulse)
        activate();
        repeat (80) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("diag masked", 32'h0, d)
        repeat (40) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("engaged ok", 32'h4, d)
        rd(sdbseq_pkg::ADDR_STATUS, d);
        `CHK("status", 4'b1011, d[3:0])
        `CHK("pulse on", 1'b1, o_test_pulse)
        `CHK("irq on", 1'b1, o_irq)
        @(posedge i_clock);
        i_torque_off_req <= 1'b0;
        i_restart_ok <= 1'b1;
        n = 0;
        while (o_torque_release !== 1'b1 && n < 400) begin
            @(posedge i_clock);
            #1 n++;
            if (n == 3) `CHK("brake off first", 1'b0, o_brake_activate)
        end
        @(posedge i_clock);
        i_restart_ok <= 1'b0;
        `CHK("restart delay", 1'b1, (n >= 100 && n <= 104))
        repeat (300) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("restart clean", 32'hC, d)
        wr(sdbseq_pkg::ADDR_IRQ_EN, 32'h0);
        #1 `CHK("irq masked", 1'b0, o_irq)
        wr(sdbseq_pkg::ADDR_IRQ_EN, 32'hF);
        wr(sdbseq_pkg::ADDR_IRQ_CLR, 32'hF);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("irq cleared", 32'h0, d)
        `CHK("irq off", 1'b0, o_irq)
    endtask

    // Contactor never closes, then a welded contactor seen while torque runs.
    task automatic t_level_faults;
        reset_cfg(2'd1);
        activate();
        repeat (400) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("open fault", 2'b10, d[1:0])
        `CHK("fault irq", 1'b1, o_irq)
        reset_cfg(2'd3);
        repeat (400) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("welded fault", 1'b1, d[1])
    endtask

    // Pulses vanish while the contact is closed: the static check must trip.
    task automatic t_static_feedback;
        reset_cfg(2'd2);
        activate();
        repeat (31000) @(posedge i_clock);
        rd(sdbseq_pkg::ADDR_IRQ_STAT, d);
        `CHK("static io err", 2'b01, d[1:0])
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        t_reset_values();
        t_normal_cycle();
        t_level_faults();
        t_static_feedback();
        stop_test();
    end

    // The whole run needs about 33000 cycles; allow close to twice that.
    initial begin
        #3000000;
        error_cnt++;
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
